// ===== inc/timer_flag_pkg.sv
// Constants shared by the timer flag and output control block
package timer_flag_pkg;
    // Register offsets on the plain register port
    localparam logic [1:0] CH1_STATUS_OFFSET = 2'h0;
    localparam logic [1:0] AUX_STATUS_OFFSET = 2'h1;
    localparam logic [1:0] GATE_SELECT_OFFSET = 2'h2;
    // Status register field positions
    localparam int COMPARE_B_FLAG_BIT = 7;
    localparam int COMPARE_A_FLAG_BIT = 6;
    localparam int OVERFLOW_FLAG_BIT = 5;
    localparam int FIXED_BIT = 4;
    localparam int ACTION_B_LSB = 2;
    localparam int ACTION_A_LSB = 0;
    localparam int INPUT_GATE_BIT = 0;
    // Reset values and fixed bits
    localparam logic [2:0] FLAGS_RESET = 3'h0;
    localparam logic [3:0] ACTIONS_RESET = 4'h0;
    localparam logic CH1_FIXED_VALUE = 1'b1;
    localparam logic AUX_FIXED_VALUE = 1'b0;
    localparam logic [6:0] GATE_RESERVED_RESET = 7'h7F;
    localparam logic GATE_ENABLE_RESET = 1'b0;
    localparam logic LEVEL_RESET = 1'b0;
    localparam logic [7:0] COUNTER_MAX = 8'hFF;
    // Output action codes; a larger code has higher priority
    typedef enum logic [1:0] {
        ACTION_HOLD = 2'h0,
        ACTION_LOW = 2'h1,
        ACTION_HIGH = 2'h2,
        ACTION_TOGGLE = 2'h3
    } output_action_t;
endpackage

// ===== hdl/compare_event_unit.sv
// Match, overflow detection and output level for one timer channel
`timescale 1ns/10ps
`default_nettype none
module compare_event_unit #(
    parameter int WIDTH = 8
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [WIDTH-1:0] i_counter,
    input wire logic [WIDTH-1:0] i_compare_a,
    input wire logic [WIDTH-1:0] i_compare_b,
    input wire logic i_count_tick,
    input wire logic [1:0] i_action_a,
    input wire logic [1:0] i_action_b,
    output logic o_match_a,
    output logic o_match_b,
    output logic o_overflow,
    output logic o_level
);
    logic level;
    logic next_level;
    logic [1:0] action;

    // Events fire on the tick that ends the matching count
    assign o_match_a = i_count_tick && (i_counter == i_compare_a);
    assign o_match_b = i_count_tick && (i_counter == i_compare_b);
    assign o_overflow = i_count_tick
        && (i_counter == timer_flag_pkg::COUNTER_MAX[WIDTH-1:0]);
    assign o_level = level;

    // Pick the winning action; code order equals priority order
    always_comb begin
        action = timer_flag_pkg::ACTION_HOLD;
        if (o_match_a) begin
            action = i_action_a;
        end
        if (o_match_b && (i_action_b > action)) begin
            action = i_action_b;
        end
        next_level = level;
        unique case (timer_flag_pkg::output_action_t'(action))
            timer_flag_pkg::ACTION_HOLD: next_level = level;
            timer_flag_pkg::ACTION_LOW: next_level = 1'b0;
            timer_flag_pkg::ACTION_HIGH: next_level = 1'b1;
            timer_flag_pkg::ACTION_TOGGLE: next_level = ~level;
        endcase
    end

    // Output level register
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            level <= timer_flag_pkg::LEVEL_RESET;
        end else begin
            level <= next_level;
        end
    end
endmodule // compare_event_unit
`default_nettype wire

// ===== hdl/timer_flag_output_control.sv
// Status flags, output control and input gate for two timer channels
// What this block does
// - Channel 1 compare-B match sets bit 7
// - Channel 1 compare-A match sets bit 6
// - Channel 1 wrap to zero sets bit 5
// - Flag clears after read-one then write-zero
// - Writing one to a flag does nothing
// - Channel 1 status bit 4 reads one
// - Aux status bit 4 reads zero
// - Compare-B match applies bits 3:2 action
// - Compare-A match applies bits 1:0 action
// - Aux compare-B match sets bit 7
// - Aux compare-A match sets bit 6
// - Aux wrap to zero sets bit 5
// - Aux compare-B match applies bits 3:2
// - Aux compare-A match applies bits 1:0
// - Aux output level stays internal, no pin
// - Gate bit 0 passes external input pin
// - Simultaneous matches: toggle, high, low, hold
// - Match event fires when counter next updates
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module timer_flag_output_control #(
    parameter int WIDTH = 8,
    parameter int CHANNELS = 2
) (
    input wire logic I_REF_CLK,
    input wire logic I_RESET_N,
    input wire logic [1:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [7:0] O_RDATA,
    input wire logic [WIDTH-1:0] I_CH1_COUNTER,
    input wire logic [WIDTH-1:0] I_CH1_COMPARE_A,
    input wire logic [WIDTH-1:0] I_CH1_COMPARE_B,
    input wire logic I_CH1_COUNT_TICK,
    input wire logic [WIDTH-1:0] I_AUX_COUNTER,
    input wire logic [WIDTH-1:0] I_AUX_COMPARE_A,
    input wire logic [WIDTH-1:0] I_AUX_COMPARE_B,
    input wire logic I_AUX_COUNT_TICK,
    input wire logic I_AUX_EXT_INPUT_PIN,
    output logic O_CH1_TIMER_OUTPUT,
    output logic O_AUX_TIMER_LEVEL,
    output logic O_AUX_EXT_INPUT
);
    // Per-channel inputs gathered into arrays
    logic [WIDTH-1:0] counter [CHANNELS];
    logic [WIDTH-1:0] compare_a [CHANNELS];
    logic [WIDTH-1:0] compare_b [CHANNELS];
    logic count_tick [CHANNELS];
    logic [1:0] chan_offset [CHANNELS];
    logic fixed_value [CHANNELS];
    logic level [CHANNELS];
    logic [7:0] status_byte [CHANNELS];

    assign counter[0] = I_CH1_COUNTER;
    assign counter[1] = I_AUX_COUNTER;
    assign compare_a[0] = I_CH1_COMPARE_A;
    assign compare_a[1] = I_AUX_COMPARE_A;
    assign compare_b[0] = I_CH1_COMPARE_B;
    assign compare_b[1] = I_AUX_COMPARE_B;
    assign count_tick[0] = I_CH1_COUNT_TICK;
    assign count_tick[1] = I_AUX_COUNT_TICK;
    assign chan_offset[0] = timer_flag_pkg::CH1_STATUS_OFFSET;
    assign chan_offset[1] = timer_flag_pkg::AUX_STATUS_OFFSET;
    assign fixed_value[0] = timer_flag_pkg::CH1_FIXED_VALUE;
    assign fixed_value[1] = timer_flag_pkg::AUX_FIXED_VALUE;

    // Channel 1 level drives the pin; aux level goes only to on-chip logic
    assign O_CH1_TIMER_OUTPUT = level[0];
    assign O_AUX_TIMER_LEVEL = level[1];

    // One status register, flag logic and event unit per channel
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            logic [2:0] flags;
            logic [2:0] next_flags;
            logic [2:0] armed;
            logic [2:0] next_armed;
            logic [3:0] actions;
            logic [3:0] next_actions;
            logic [2:0] events;
            logic match_a;
            logic match_b;
            logic overflow;
            logic wr_sel;
            logic rd_sel;
            logic [2:0] wr_flags;

            compare_event_unit #(
                .WIDTH(WIDTH)
            ) u_events (
                .i_clk(I_REF_CLK),
                .i_reset_n(I_RESET_N),
                .i_counter(counter[ch]),
                .i_compare_a(compare_a[ch]),
                .i_compare_b(compare_b[ch]),
                .i_count_tick(count_tick[ch]),
                .i_action_a(actions[timer_flag_pkg::ACTION_A_LSB +: 2]),
                .i_action_b(actions[timer_flag_pkg::ACTION_B_LSB +: 2]),
                .o_match_a(match_a),
                .o_match_b(match_b),
                .o_overflow(overflow),
                .o_level(level[ch])
            );

            // Event vector in flag order B, A, overflow
            assign events = {match_b, match_a, overflow};
            assign wr_sel = I_WR && (I_ADDR == chan_offset[ch]);
            assign rd_sel = I_RD && (I_ADDR == chan_offset[ch]);
            assign wr_flags = I_WDATA[timer_flag_pkg::OVERFLOW_FLAG_BIT +: 3];
            assign status_byte[ch] = {flags, fixed_value[ch], actions};

            // Flags: armed by a read of one, cleared by a later zero write
            always_comb begin
                next_flags = flags;
                next_armed = armed;
                next_actions = actions;
                if (rd_sel) begin
                    next_armed = armed | flags;
                end
                if (wr_sel) begin
                    next_flags = flags & ~(armed & ~wr_flags);
                    next_armed = 3'h0;
                    next_actions = I_WDATA[3:0];
                end
                next_flags = next_flags | events;
            end

            // Channel state registers
            always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
                if (!I_RESET_N) begin
                    flags <= timer_flag_pkg::FLAGS_RESET;
                    armed <= timer_flag_pkg::FLAGS_RESET;
                    actions <= timer_flag_pkg::ACTIONS_RESET;
                end else begin
                    flags <= next_flags;
                    armed <= next_armed;
                    actions <= next_actions;
                end
            end
        end
    endgenerate

    // Input gate select register
    logic [6:0] gate_reserved;
    logic [6:0] next_gate_reserved;
    logic gate_enable;
    logic next_gate_enable;

    // Reserved bits are stored as written; software keeps them at ones
    always_comb begin
        next_gate_reserved = gate_reserved;
        next_gate_enable = gate_enable;
        if (I_WR && (I_ADDR == timer_flag_pkg::GATE_SELECT_OFFSET)) begin
            next_gate_reserved = I_WDATA[7:1];
            next_gate_enable = I_WDATA[timer_flag_pkg::INPUT_GATE_BIT];
        end
    end

    // Gate register flops
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            gate_reserved <= timer_flag_pkg::GATE_RESERVED_RESET;
            gate_enable <= timer_flag_pkg::GATE_ENABLE_RESET;
        end else begin
            gate_reserved <= next_gate_reserved;
            gate_enable <= next_gate_enable;
        end
    end

    // External input pin synchroniser and agreement filter
    logic [2:0] pin_sync;
    logic pin_level;
    logic next_pin_level;
    logic ext_input;
    logic next_ext_input;

    // Level changes only once the second and third stages agree
    always_comb begin
        next_pin_level = pin_level;
        if (pin_sync[1] == pin_sync[2]) begin
            next_pin_level = pin_sync[2];
        end
        next_ext_input = next_pin_level && gate_enable;
    end

    // Synchroniser and gated output flops
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            pin_sync <= 3'h0;
            pin_level <= 1'b0;
            ext_input <= 1'b0;
        end else begin
            pin_sync <= {pin_sync[1:0], I_AUX_EXT_INPUT_PIN};
            pin_level <= next_pin_level;
            ext_input <= next_ext_input;
        end
    end

    assign O_AUX_EXT_INPUT = ext_input;

    // Read data, valid only in the cycle after the read strobe
    logic [7:0] rdata;
    logic [7:0] next_rdata;

    // Read mux; unmapped offsets read zero
    always_comb begin
        next_rdata = 8'h00;
        if (I_RD) begin
            unique case (I_ADDR)
                timer_flag_pkg::CH1_STATUS_OFFSET: next_rdata = status_byte[0];
                timer_flag_pkg::AUX_STATUS_OFFSET: next_rdata = status_byte[1];
                timer_flag_pkg::GATE_SELECT_OFFSET: next_rdata = {gate_reserved, gate_enable};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // Read data register
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign O_RDATA = rdata;
endmodule // timer_flag_output_control
`default_nettype wire

// ===== verification/timer_flag_assertions.sv
// Concurrent checks on the timer flag and output control ports
`timescale 1ns/10ps
`default_nettype none
module timer_flag_assertions #(
    parameter int WIDTH = 8
) (
    input wire logic I_REF_CLK,
    input wire logic I_RESET_N,
    input wire logic [1:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [7:0] O_RDATA,
    input wire logic [WIDTH-1:0] I_CH1_COUNTER,
    input wire logic [WIDTH-1:0] I_CH1_COMPARE_A,
    input wire logic [WIDTH-1:0] I_CH1_COMPARE_B,
    input wire logic I_CH1_COUNT_TICK,
    input wire logic [WIDTH-1:0] I_AUX_COUNTER,
    input wire logic I_AUX_COUNT_TICK,
    input wire logic O_CH1_TIMER_OUTPUT,
    input wire logic O_AUX_TIMER_LEVEL,
    input wire logic O_AUX_EXT_INPUT
);
    logic [3:0] act1;
    logic [3:0] next_act1;
    wire hit_a = I_CH1_COUNT_TICK && I_CH1_COUNTER == I_CH1_COMPARE_A;
    wire hit_b = I_CH1_COUNT_TICK && I_CH1_COUNTER == I_CH1_COMPARE_B;
    // Shadow of the channel 1 action fields
    always_comb begin
        next_act1 = act1;
        if (I_WR && I_ADDR == 2'h0) begin
            next_act1 = I_WDATA[3:0];
        end
    end
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            act1 <= 4'h0;
        end else begin
            act1 <= next_act1;
        end
    end
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RESET_N);
    // Register reads
    sequence s_rd_ch1; I_RD && I_ADDR == 2'h0; endsequence
    sequence s_rd_aux; I_RD && I_ADDR == 2'h1; endsequence
    a_ch1_fixed_one: assert property (s_rd_ch1 |=> O_RDATA[4])
        else $error("channel 1 bit 4 not one");
    a_aux_fixed_zero: assert property (s_rd_aux |=> !O_RDATA[4])
        else $error("aux bit 4 not zero");
    a_ch1_flag_b: assert property (hit_b ##1 s_rd_ch1 |=> O_RDATA[7])
        else $error("compare B flag missing");
    a_ch1_flag_a: assert property (hit_a ##1 s_rd_ch1 |=> O_RDATA[6])
        else $error("compare A flag missing");
    a_aux_overflow: assert property (
        I_AUX_COUNT_TICK && I_AUX_COUNTER == 8'hFF ##1 s_rd_aux |=> O_RDATA[5])
        else $error("aux overflow flag missing");
    a_gate_closed: assert property (
        I_WR && I_ADDR == 2'h2 && !I_WDATA[0] |-> ##2 !O_AUX_EXT_INPUT)
        else $error("gated input passes while closed");
    a_no_tick_hold: assert property (
        !I_CH1_COUNT_TICK |=> $stable(O_CH1_TIMER_OUTPUT))
        else $error("channel 1 output moved without tick");
    a_aux_no_tick: assert property (
        !I_AUX_COUNT_TICK |=> $stable(O_AUX_TIMER_LEVEL))
        else $error("aux level moved without tick");
    a_a_high: assert property (
        hit_a && !hit_b && act1[1:0] == 2'h2 |=> O_CH1_TIMER_OUTPUT)
        else $error("compare A high action failed");
    a_b_low: assert property (
        hit_b && !hit_a && act1[3:2] == 2'h1 |=> !O_CH1_TIMER_OUTPUT)
        else $error("compare B low action failed");
    a_toggle_wins: assert property (
        hit_a && hit_b && (act1[1:0] == 2'h3 || act1[3:2] == 2'h3)
        |=> O_CH1_TIMER_OUTPUT != $past(O_CH1_TIMER_OUTPUT))
        else $error("toggle did not win");
endmodule // timer_flag_assertions
bind timer_flag_output_control timer_flag_assertions #(.WIDTH(WIDTH)) u_chk (.I_REF_CLK,
    .I_RESET_N, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA, .I_CH1_COUNTER, .I_CH1_COMPARE_A,
    .I_CH1_COMPARE_B, .I_CH1_COUNT_TICK, .I_AUX_COUNTER, .I_AUX_COUNT_TICK,
    .O_CH1_TIMER_OUTPUT, .O_AUX_TIMER_LEVEL, .O_AUX_EXT_INPUT);
`default_nettype wire

// ===== verification/ext_pin_partner.sv
// External pin partner driving the aux input pin
`timescale 1ns/10ps
`default_nettype none
module ext_pin_partner #(
    parameter int SKEW_NS = 2
) (
    input wire logic i_level,
    output logic o_pin
);
    // Pin follows the request after a skew unrelated to the clock
    initial begin
        o_pin = 1'b0;
        forever begin
            @(i_level);
            o_pin <= #(SKEW_NS) i_level;
        end
    end
endmodule // ext_pin_partner
`default_nettype wire

// ===== verification/timer_flag_output_control_test.sv
// Self-checking bench for the timer flag and output control block
`timescale 1ns/10ps
`default_nettype none
module timer_flag_output_control_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0, rd = 1'b0, lvl_req = 1'b0, pin, out1, outy, extin;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00, rdata;
    logic tick [2] = '{1'b0, 1'b0};
    logic [7:0] cnt [2] = '{8'h00, 8'h00};
    logic [7:0] cmpa [2] = '{8'h10, 8'h30};
    logic [7:0] cmpb [2] = '{8'h20, 8'h40};
    logic [7:0] nca [2] = '{8'h10, 8'h30};
    logic [7:0] ncb [2] = '{8'h20, 8'h40};
    logic [31:0] r;
    int flg [2] = '{0, 0}, arm [2] = '{0, 0}, act [2] = '{0, 0}, lvl [2] = '{0, 0};
    int gate = 254, exp_rd = 0, seed = 78, miscompares = 0, num_checks = 0, i;
    timer_flag_output_control DUT (.I_REF_CLK(clk), .I_RESET_N(rst_n), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_CH1_COUNTER(cnt[0]),
        .I_CH1_COMPARE_A(cmpa[0]), .I_CH1_COMPARE_B(cmpb[0]), .I_CH1_COUNT_TICK(tick[0]),
        .I_AUX_COUNTER(cnt[1]), .I_AUX_COMPARE_A(cmpa[1]), .I_AUX_COMPARE_B(cmpb[1]),
        .I_AUX_COUNT_TICK(tick[1]), .I_AUX_EXT_INPUT_PIN(pin), .O_CH1_TIMER_OUTPUT(out1),
        .O_AUX_TIMER_LEVEL(outy), .O_AUX_EXT_INPUT(extin));
    ext_pin_partner #(.SKEW_NS(2)) partner (.i_level(lvl_req), .o_pin(pin));
    // Clock at 200 MHz
    always #2.5 clk = ~clk;
    // Reference model, advanced with the inputs sampled at this edge
    task automatic model();
        int c, ma, mb, code;
        exp_rd = 0;
        for (c = 0; c < 2; c++) begin
            ma = tick[c] && cnt[c] == cmpa[c];
            mb = tick[c] && cnt[c] == cmpb[c];
            if (rd && addr == c) begin
                exp_rd = flg[c] << 5 | (c == 0) << 4 | act[c];
                arm[c] |= flg[c];
            end
            if (wr && addr == c) begin
                flg[c] &= ~(arm[c] & ~(wdata >> 5));
                arm[c] = 0;
                act[c] = wdata & 15;
            end
            flg[c] |= mb << 2 | ma << 1 | (tick[c] && cnt[c] == 255);
            code = ma ? act[c] & 3 : 0;
            if (mb && act[c] >> 2 > code) code = act[c] >> 2;
            if (code == 3) lvl[c] ^= 1;
            else if (code != 0) lvl[c] = code - 1;
        end
        if (rd && addr == 2) exp_rd = gate;
        if (wr && addr == 2) gate = wdata;
    endtask
    // Comparisons
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t level %b expected %b", $time, got, exp);
        end
    endtask
    // One cycle of bus and counter stimulus, then compare
    task automatic op(input logic w, input logic rq, input logic [1:0] a, input logic [7:0] d,
                      input logic [1:0] t, input logic [7:0] n0, input logic [7:0] n1);
        @(posedge clk);
        model();
        wr <= w;
        rd <= rq;
        addr <= a;
        wdata <= d;
        tick <= '{t[0], t[1]};
        cnt <= '{n0, n1};
        cmpa <= nca;
        cmpb <= ncb;
        @(negedge clk);
        chk8(rdata, exp_rd[7:0]);
        chk1(out1, lvl[0][0]);
        chk1(outy, lvl[1][0]);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        summarize();
    end
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 4; i++) op(0, 1, i[1:0], 0, 0, 0, 0);
        op(0, 0, 0, 0, 2'h3, 8'h10, 8'h40);
        op(0, 0, 0, 0, 2'h0, 8'h20, 8'h30);
        op(0, 1, 0, 0, 0, 0, 0);
        op(1, 0, 0, 8'hFF, 2'h3, 8'hFF, 8'hFF);
        op(1, 0, 0, 8'h00, 0, 0, 0);
        op(0, 1, 0, 0, 0, 0, 0);
        // Clear of the compare-A flag meets a new compare-A event
        op(1, 0, 0, 8'h00, 2'h1, 8'h10, 0);
        op(0, 0, 0, 0, 2'h1, 8'h20, 0);
        op(0, 1, 0, 0, 0, 0, 0);
        op(0, 1, 1, 0, 0, 0, 0);
        op(1, 0, 1, 8'h0F, 0, 0, 0);
        // Every action code pair, single and joint matches
        for (i = 0; i < 16; i++) begin
            op(1, 0, 0, i[7:0], 0, 0, 0);
            op(1, 0, 1, i[7:0], 0, 0, 0);
            op(0, 0, 0, 0, 2'h3, 8'h10, 8'h30);
            op(0, 0, 0, 0, 2'h3, 8'h20, 8'h40);
            ncb = nca;
            op(0, 0, 0, 0, 0, 0, 0);
            op(0, 0, 0, 0, 2'h3, 8'h10, 8'h30);
            ncb = '{8'h20, 8'h40};
        end
        // Random traffic near the wrap point, gate reserved bits kept high
        for (i = 0; i < 300; i++) begin
            r = $random(seed);
            nca = '{{6'h3F, r[21:20]}, {6'h3F, r[23:22]}};
            ncb = '{{6'h3F, r[25:24]}, {6'h3F, r[27:26]}};
            op(r[2] & ~r[3], r[3], r[5:4], r[15:8] | (r[5:4] == 2'h2 ? 8'hFE : 8'h00),
               r[7:6], {6'h3F, r[17:16]}, {6'h3F, r[19:18]});
        end
        op(1, 0, 2, 8'hFF, 0, 0, 0);
        lvl_req <= 1'b1;
        repeat (8) op(0, 0, 0, 0, 0, 0, 0);
        chk1(extin, 1'b1);
        op(1, 0, 2, 8'hFE, 0, 0, 0);
        repeat (3) op(0, 0, 0, 0, 0, 0, 0);
        chk1(extin, 1'b0);
        summarize();
    end
endmodule // timer_flag_output_control_test
`default_nettype wire
